// file: adm_pkg.sv
// Purpose: shared constants and types of the converter mode control bank
// Assumes: control words arrive whole through the register bus
// Notes:   byte address of a mode register is four times its index
package adm_pkg;

	// control word carrier, bit 15 down to bit 0
	typedef struct packed {
		logic       must_be_zero;
		logic [6:0] reg_index_field;
		logic [7:0] data;
	} adm_cw_s;

	// mode register indexes
	localparam logic [6:0] ADM_IDX_RATE_RESET    = 7'h12;
	localparam logic [6:0] ADM_IDX_OUTPUT_DEEMPH = 7'h13;
	localparam logic [6:0] ADM_IDX_FORMAT_FILTER = 7'h14;
	localparam logic [6:0] ADM_IDX_PHASE_ZERO    = 7'h16;

	// own bus registers, byte addresses
	localparam logic [7:0] ADM_OFF_CMD_WORD = 8'h00;
	localparam logic [7:0] ADM_OFF_INT_STAT = 8'h04;
	localparam logic [7:0] ADM_OFF_INT_MASK = 8'h08;

	// field positions inside the data byte
	localparam int ADM_POS_SOFT_REINIT  = 7;
	localparam int ADM_POS_OVER_SEL     = 6;
	localparam int ADM_POS_DEEMPH_RATE  = 5;
	localparam int ADM_POS_DEEMPH_ON    = 4;
	localparam int ADM_POS_OFF_RIGHT    = 1;
	localparam int ADM_POS_OFF_LEFT     = 0;
	localparam int ADM_POS_ROLLOFF      = 5;
	localparam int ADM_POS_FORMAT       = 0;
	localparam int ADM_POS_ZF_MERGE     = 2;
	localparam int ADM_POS_ZF_POLARITY  = 1;
	localparam int ADM_POS_PHASE_INVERT = 0;

	// audio word format codes
	localparam logic [2:0] ADM_FMT_RJ24 = 3'h0;
	localparam logic [2:0] ADM_FMT_RJ20 = 3'h1;
	localparam logic [2:0] ADM_FMT_RJ18 = 3'h2;
	localparam logic [2:0] ADM_FMT_RJ16 = 3'h3;
	localparam logic [2:0] ADM_FMT_I2S  = 3'h4;
	localparam logic [2:0] ADM_FMT_LJ   = 3'h5;
	localparam logic [1:0] ADM_DEEMPH_RSVD = 2'h3;

	// modulator ratios
	localparam logic [7:0] ADM_OSR_32  = 8'h20;
	localparam logic [7:0] ADM_OSR_64  = 8'h40;
	localparam logic [7:0] ADM_OSR_128 = 8'h80;

	// interrupt events
	localparam int ADM_EV_W      = 3;
	localparam int ADM_EV_ACCEPT = 0;
	localparam int ADM_EV_REJECT = 1;
	localparam int ADM_EV_REINIT = 2;

	typedef struct packed {
		logic       over_sel;
		logic [1:0] channel_output_off;
		logic       deemph_on;
		logic [1:0] deemph_rate_sel;
		logic [2:0] audio_word_format;
		logic       rolloff_select;
		logic       phase_invert;
		logic       zero_flag_polarity;
		logic       zero_flag_merge;
	} adm_mode_s;

	localparam adm_mode_s ADM_MODE_DEFAULT = '{
		over_sel:           1'b0,
		channel_output_off: 2'h0,
		deemph_on:          1'b0,
		deemph_rate_sel:    2'h0,
		audio_word_format:  ADM_FMT_LJ,
		rolloff_select:     1'b0,
		phase_invert:       1'b0,
		zero_flag_polarity: 1'b0,
		zero_flag_merge:    1'b0
	};

	// zero flag pins: pin_a carries right or joint flag, pin_b left
	typedef struct packed {
		logic pin_a;
		logic pin_b;
	} adm_zpin_s;

	typedef enum logic [2:0] {
		ADM_ADDR_CMD,
		ADM_ADDR_STAT,
		ADM_ADDR_MASK,
		ADM_ADDR_RB_RATE,
		ADM_ADDR_RB_OUT,
		ADM_ADDR_RB_FMT,
		ADM_ADDR_RB_PHASE,
		ADM_ADDR_NONE
	} adm_addr_e;

	typedef struct packed {
		adm_mode_s             mode;
		logic [7:0]            osr_ratio;
		logic [4:0]            rj_word_bits;
		logic                  i2s_frame;
		logic                  left_just_frame;
		logic                  fmt_valid;
		logic                  deemph_rate_valid;
		logic [ADM_EV_W-1:0]   int_stat;
		logic [ADM_EV_W-1:0]   int_mask;
		logic [31:0]           prdata;
	} adm_core_s;

endpackage

// file: adm_cw_decode.sv
// Purpose: decode a control word into a one-hot mode register select
// Assumes: purely combinational, used inside the bank
// Notes:   unknown index gives no select; a set top bit keeps the select but clears o_valid
`timescale 1ns/100ps
module adm_cw_decode (
	// word in
	input  wire adm_pkg::adm_cw_s i_cw,
	// select out
	output logic [3:0]            o_sel,
	output logic                  o_valid
);
	always_comb begin
		o_sel = 4'h0;
		case (i_cw.reg_index_field)
			adm_pkg::ADM_IDX_RATE_RESET:    o_sel = 4'h1;
			adm_pkg::ADM_IDX_OUTPUT_DEEMPH: o_sel = 4'h2;
			adm_pkg::ADM_IDX_FORMAT_FILTER: o_sel = 4'h4;
			adm_pkg::ADM_IDX_PHASE_ZERO:    o_sel = 4'h8;
			default:                        o_sel = 4'h0;
		endcase
		// framing bit must be zero for a usable word
		o_valid = !i_cw.must_be_zero && (o_sel != 4'h0);
	end
endmodule

// file: adm_zero_flag.sv
// Purpose: map channel zero detections onto the two zero flag pins
// Assumes: detections are synchronous to the system clock
// Notes:   unassigned pin rests at its inactive level
`timescale 1ns/100ps
module adm_zero_flag (
	// clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_arst_n,
	// detections and mode
	input  wire logic              i_left_zero,
	input  wire logic              i_right_zero,
	input  wire logic              i_merge,
	input  wire logic              i_polarity,
	// pins
	output adm_pkg::adm_zpin_s     o_pins
);
	adm_pkg::adm_zpin_s pins_r;
	adm_pkg::adm_zpin_s pins_nxt;

	always_comb begin
		pins_nxt = pins_r;
		if (i_merge) begin
			pins_nxt.pin_a = (i_left_zero && i_right_zero) ^ i_polarity;
			pins_nxt.pin_b = i_polarity;
		end else begin
			pins_nxt.pin_a = i_right_zero ^ i_polarity;
			pins_nxt.pin_b = i_left_zero ^ i_polarity;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pins_r <= '0;
		end else begin
			pins_r <= pins_nxt;
		end
	end

	assign o_pins = pins_r;
endmodule

// file: adm_mode_bank.sv
// Purpose: mode control register bank of a stereo audio converter
// Assumes: APB master, zero-wait slave, one clock domain
// Notes:   mode registers are written only through the command word
//
// Summary of operation
// - over_sel picks 64x/128x, or 32x/64x with 128/192 fs clocks.
// - soft_reinit write returns every mode field to its default.
// - channel_output_off forces that channel to bipolar zero; default clear.
// - deemph_on enables de-emphasis; resets to off.
// - deemph_rate_sel: 00 44.1k, 01 48k, 10 32k, 11 reserved.
// - format codes 000..011 select right-justified 24, 20, 18, 16 bits.
// - code 100 is I2S, 101 left-justified default, 110/111 reserved.
// - rolloff_select clear is sharp, set is slow rolloff.
// - phase_invert set inverts the analog output phase.
// - zero_flag_polarity clear drives pins high on zero, set low.
// - zero_flag_merge set gives one joint flag, other pin unassigned.
// - control word: bit 15 zero, index bits 14..8, data 7..0.
`timescale 1ns/100ps
module adm_mode_bank #(
	parameter int P_ADDR_W = 12
) (
	// clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_arst_n,
	// apb slave
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [P_ADDR_W-1:0]   i_paddr,
	input  wire logic [31:0]           i_pwdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	output logic [31:0]                o_prdata,
	// converter status
	input  wire logic                  i_base_clk_low,
	input  wire logic                  i_left_zero,
	input  wire logic                  i_right_zero,
	// mode outputs
	output adm_pkg::adm_mode_s         o_mode,
	output logic [7:0]                 o_osr_ratio,
	output logic [4:0]                 o_rj_word_bits,
	output logic                       o_i2s_frame,
	output logic                       o_left_just_frame,
	output logic                       o_fmt_valid,
	output logic                       o_deemph_rate_valid,
	output adm_pkg::adm_zpin_s         o_zero_pins,
	// interrupt
	output logic                       o_irq
);
	// the page select slice a[P_ADDR_W-1:8] needs at least one bit
	if (P_ADDR_W < 9) begin : g_addr_check
		$error("P_ADDR_W must be at least 9");
	end

	adm_pkg::adm_core_s s_r;
	adm_pkg::adm_core_s s_nxt;
	adm_pkg::adm_cw_s   cw;
	logic [3:0]         cw_sel;
	logic               cw_valid;
	logic               acc;
	logic               take_wr;
	adm_pkg::adm_addr_e acc_kind;
	localparam int ADM_EV_W_L = adm_pkg::ADM_EV_W;

	assign cw = i_pwdata[15:0];

	adm_cw_decode u_decode (
		.i_cw    (cw),
		.o_sel   (cw_sel),
		.o_valid (cw_valid)
	);

	function automatic adm_pkg::adm_addr_e addr_kind(
		input logic [P_ADDR_W-1:0] a
	);
		logic [7:0] lo;
		lo = a[7:0];
		addr_kind = adm_pkg::ADM_ADDR_NONE;
		if (a[P_ADDR_W-1:8] == '0) begin
			case (lo)
				adm_pkg::ADM_OFF_CMD_WORD:
					addr_kind = adm_pkg::ADM_ADDR_CMD;
				adm_pkg::ADM_OFF_INT_STAT:
					addr_kind = adm_pkg::ADM_ADDR_STAT;
				adm_pkg::ADM_OFF_INT_MASK:
					addr_kind = adm_pkg::ADM_ADDR_MASK;
				{adm_pkg::ADM_IDX_RATE_RESET[5:0], 2'h0}:
					addr_kind = adm_pkg::ADM_ADDR_RB_RATE;
				{adm_pkg::ADM_IDX_OUTPUT_DEEMPH[5:0], 2'h0}:
					addr_kind = adm_pkg::ADM_ADDR_RB_OUT;
				{adm_pkg::ADM_IDX_FORMAT_FILTER[5:0], 2'h0}:
					addr_kind = adm_pkg::ADM_ADDR_RB_FMT;
				{adm_pkg::ADM_IDX_PHASE_ZERO[5:0], 2'h0}:
					addr_kind = adm_pkg::ADM_ADDR_RB_PHASE;
				default:
					addr_kind = adm_pkg::ADM_ADDR_NONE;
			endcase
		end
	endfunction

	// readback packs fields at their write positions, test bits read zero
	function automatic logic [7:0] mode_byte(
		input adm_pkg::adm_mode_s m,
		input adm_pkg::adm_addr_e k
	);
		logic [7:0] b;
		b = 8'h00;
		case (k)
			adm_pkg::ADM_ADDR_RB_RATE: begin
				b[adm_pkg::ADM_POS_OVER_SEL] = m.over_sel;
			end
			adm_pkg::ADM_ADDR_RB_OUT: begin
				b[adm_pkg::ADM_POS_DEEMPH_RATE +: 2] = m.deemph_rate_sel;
				b[adm_pkg::ADM_POS_DEEMPH_ON] = m.deemph_on;
				b[adm_pkg::ADM_POS_OFF_RIGHT] = m.channel_output_off[1];
				b[adm_pkg::ADM_POS_OFF_LEFT]  = m.channel_output_off[0];
			end
			adm_pkg::ADM_ADDR_RB_FMT: begin
				b[adm_pkg::ADM_POS_ROLLOFF] = m.rolloff_select;
				b[adm_pkg::ADM_POS_FORMAT +: 3] = m.audio_word_format;
			end
			adm_pkg::ADM_ADDR_RB_PHASE: begin
				b[adm_pkg::ADM_POS_ZF_MERGE]     = m.zero_flag_merge;
				b[adm_pkg::ADM_POS_ZF_POLARITY]  = m.zero_flag_polarity;
				b[adm_pkg::ADM_POS_PHASE_INVERT] = m.phase_invert;
			end
			default: begin
				b = 8'h00;
			end
		endcase
		mode_byte = b;
	endfunction

	assign acc      = i_psel && i_penable;
	assign take_wr  = acc && i_pwrite;
	assign acc_kind = addr_kind(i_paddr);

	always_comb begin
		logic [ADM_EV_W_L-1:0] ev;
		logic [ADM_EV_W_L-1:0] clr;
		ev    = '0;
		clr   = '0;
		s_nxt = s_r;
		if (take_wr && acc_kind == adm_pkg::ADM_ADDR_CMD) begin
			// whole word taken at the access edge only
			if (cw_valid) begin
				ev[adm_pkg::ADM_EV_ACCEPT] = 1'b1;
				// only the addressed register moves, except a soft reinit, which returns every register to default
				if (cw_sel[0]) begin
					if (cw.data[adm_pkg::ADM_POS_SOFT_REINIT]) begin
						// same as power-on, bit itself is not kept
						s_nxt.mode = adm_pkg::ADM_MODE_DEFAULT;
						ev[adm_pkg::ADM_EV_REINIT] = 1'b1;
					end else begin
						s_nxt.mode.over_sel =
							cw.data[adm_pkg::ADM_POS_OVER_SEL];
					end
				end
				if (cw_sel[1]) begin
					s_nxt.mode.channel_output_off = {
						cw.data[adm_pkg::ADM_POS_OFF_RIGHT],
						cw.data[adm_pkg::ADM_POS_OFF_LEFT]};
					s_nxt.mode.deemph_on =
						cw.data[adm_pkg::ADM_POS_DEEMPH_ON];
					s_nxt.mode.deemph_rate_sel =
						cw.data[adm_pkg::ADM_POS_DEEMPH_RATE +: 2];
				end
				if (cw_sel[2]) begin
					s_nxt.mode.rolloff_select =
						cw.data[adm_pkg::ADM_POS_ROLLOFF];
					s_nxt.mode.audio_word_format =
						cw.data[adm_pkg::ADM_POS_FORMAT +: 3];
				end
				if (cw_sel[3]) begin
					s_nxt.mode.zero_flag_merge =
						cw.data[adm_pkg::ADM_POS_ZF_MERGE];
					s_nxt.mode.zero_flag_polarity =
						cw.data[adm_pkg::ADM_POS_ZF_POLARITY];
					s_nxt.mode.phase_invert =
						cw.data[adm_pkg::ADM_POS_PHASE_INVERT];
				end
			end else begin
				ev[adm_pkg::ADM_EV_REJECT] = 1'b1;
			end
		end
		if (take_wr && acc_kind == adm_pkg::ADM_ADDR_MASK) begin
			s_nxt.int_mask = i_pwdata[ADM_EV_W_L-1:0];
		end
		if (take_wr && acc_kind == adm_pkg::ADM_ADDR_STAT) begin
			clr = i_pwdata[ADM_EV_W_L-1:0];
		end
		// a new event wins over a clear in the same cycle
		s_nxt.int_stat = (s_r.int_stat & ~clr) | ev;

		// slow clocks halve the ratio
		if (i_base_clk_low) begin
			s_nxt.osr_ratio = s_nxt.mode.over_sel ?
				adm_pkg::ADM_OSR_64 : adm_pkg::ADM_OSR_32;
		end else begin
			s_nxt.osr_ratio = s_nxt.mode.over_sel ?
				adm_pkg::ADM_OSR_128 : adm_pkg::ADM_OSR_64;
		end
		s_nxt.deemph_rate_valid =
			s_nxt.mode.deemph_rate_sel != adm_pkg::ADM_DEEMPH_RSVD;
		s_nxt.rj_word_bits    = 5'h00;
		s_nxt.i2s_frame       = 1'b0;
		s_nxt.left_just_frame = 1'b0;
		s_nxt.fmt_valid       = 1'b1;
		case (s_nxt.mode.audio_word_format)
			adm_pkg::ADM_FMT_RJ24: s_nxt.rj_word_bits = 5'h18;
			adm_pkg::ADM_FMT_RJ20: s_nxt.rj_word_bits = 5'h14;
			adm_pkg::ADM_FMT_RJ18: s_nxt.rj_word_bits = 5'h12;
			adm_pkg::ADM_FMT_RJ16: s_nxt.rj_word_bits = 5'h10;
			adm_pkg::ADM_FMT_I2S:  s_nxt.i2s_frame = 1'b1;
			adm_pkg::ADM_FMT_LJ:   s_nxt.left_just_frame = 1'b1;
			default:               s_nxt.fmt_valid = 1'b0;
		endcase

		// read data captured in setup so the access phase needs no wait
		if (i_psel && !i_penable && !i_pwrite) begin
			case (acc_kind)
				adm_pkg::ADM_ADDR_STAT:
					s_nxt.prdata = {29'h0, s_r.int_stat};
				adm_pkg::ADM_ADDR_MASK:
					s_nxt.prdata = {29'h0, s_r.int_mask};
				default:
					s_nxt.prdata = {24'h0, mode_byte(s_r.mode, acc_kind)};
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r                   <= '0;
			s_r.mode              <= adm_pkg::ADM_MODE_DEFAULT;
			s_r.osr_ratio         <= adm_pkg::ADM_OSR_64;
			s_r.left_just_frame   <= 1'b1;
			s_r.fmt_valid         <= 1'b1;
			s_r.deemph_rate_valid <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	adm_zero_flag u_zero (
		.i_sys_clk    (i_sys_clk),
		.i_arst_n     (i_arst_n),
		.i_left_zero  (i_left_zero),
		.i_right_zero (i_right_zero),
		.i_merge      (s_r.mode.zero_flag_merge),
		.i_polarity   (s_r.mode.zero_flag_polarity),
		.o_pins       (o_zero_pins)
	);

	// unmapped addresses answer with an error, nothing stored
	assign o_pready            = 1'b1;
	assign o_pslverr           = acc && (acc_kind == adm_pkg::ADM_ADDR_NONE);
	assign o_prdata            = s_r.prdata;
	assign o_mode              = s_r.mode;
	assign o_osr_ratio         = s_r.osr_ratio;
	assign o_rj_word_bits      = s_r.rj_word_bits;
	assign o_i2s_frame         = s_r.i2s_frame;
	assign o_left_just_frame   = s_r.left_just_frame;
	assign o_fmt_valid         = s_r.fmt_valid;
	assign o_deemph_rate_valid = s_r.deemph_rate_valid;
	assign o_irq               = |(s_r.int_stat & s_r.int_mask);

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_word_take;
		take_wr && acc_kind == adm_pkg::ADM_ADDR_CMD && !i_pwdata[15];
	endsequence

	sequence s_word_to(logic [6:0] idx);
		s_word_take ##0 (i_pwdata[14:8] == idx);
	endsequence

	ratio_follows_a: assert property (
		$past(i_arst_n) |-> o_osr_ratio == ($past(i_base_clk_low) ?
			(o_mode.over_sel ? 8'h40 : 8'h20) :
			(o_mode.over_sel ? 8'h80 : 8'h40)))
		else $error("modulator ratio does not follow mode");

	soft_reinit_a: assert property (
		s_word_to(7'h12) ##0 i_pwdata[7] |=>
			o_mode == adm_pkg::ADM_MODE_DEFAULT && s_r.int_stat[2]
			&& o_left_just_frame)
		else $error("soft reinit left a field changed");

	chan_off_a: assert property (
		s_word_to(7'h13) |=> o_mode.channel_output_off == $past(i_pwdata[1:0]))
		else $error("channel output off not taken");

	deemph_set_a: assert property (
		s_word_to(7'h13) |=> o_mode.deemph_on == $past(i_pwdata[4])
			&& o_deemph_rate_valid == ($past(i_pwdata[6:5]) != 2'h3))
		else $error("de-emphasis fields wrong");

	fmt_rj_a: assert property (
		s_word_to(7'h14) ##0 (i_pwdata[2:0] == 3'h2) |=>
			o_rj_word_bits == 5'h12 && !o_i2s_frame && o_fmt_valid)
		else $error("right justified width wrong");

	fmt_frame_a: assert property (
		s_word_to(7'h14) ##0 (i_pwdata[2:1] == 2'h3) |=>
			!o_fmt_valid && o_rj_word_bits == 5'h00 && !o_left_just_frame)
		else $error("reserved format accepted");

	rolloff_phase_a: assert property (
		s_word_to(7'h14) |=> o_mode.rolloff_select == $past(i_pwdata[5])
			&& $stable(o_mode.phase_invert))
		else $error("rolloff select wrong");

	zero_pin_a: assert property (
		$past(i_arst_n) |-> o_zero_pins.pin_a ==
			(($past(o_mode.zero_flag_merge) ?
				($past(i_left_zero) && $past(i_right_zero)) :
				$past(i_right_zero)) ^ $past(o_mode.zero_flag_polarity)))
		else $error("zero flag pin wrong");

	zero_pin_b_a: assert property (
		$past(i_arst_n) |-> o_zero_pins.pin_b ==
			($past(o_mode.zero_flag_merge) ?
				$past(o_mode.zero_flag_polarity) :
				($past(i_left_zero) ^ $past(o_mode.zero_flag_polarity))))
		else $error("second zero flag pin wrong");

	frame_bit_a: assert property (
		take_wr && acc_kind == adm_pkg::ADM_ADDR_CMD && i_pwdata[15]
		|=> $stable(o_mode) && s_r.int_stat[1])
		else $error("word with top bit set was used");

	other_reg_a: assert property (
		s_word_to(7'h16) |=> $stable(o_mode.channel_output_off)
			&& $stable(o_mode.audio_word_format)
			&& o_mode.phase_invert == $past(i_pwdata[0]))
		else $error("word changed another register");

endmodule

// file: adm_host_model.sv
// Purpose: host side model, apb master sending control words
// Assumes: one transfer at a time, started by the bench
// Notes:   waits on pready, assumes no wait-state count
`timescale 1ns/100ps
module adm_host_model #(
	parameter int P_ADDR_W = 12
) (
	// clock
	input  wire logic                i_sys_clk,
	// apb master
	output logic                     o_psel,
	output logic                     o_penable,
	output logic                     o_pwrite,
	output logic [P_ADDR_W-1:0]      o_paddr,
	output logic [31:0]              o_pwdata,
	input  wire logic                i_pready,
	input  wire logic                i_pslverr,
	input  wire logic [31:0]         i_prdata
);
	initial begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = '0;
		o_pwdata  = 32'h0;
	end

	// request held until pready is seen at a rising edge
	task automatic xfer(input logic wr, input logic [P_ADDR_W-1:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge i_sys_clk);
		o_psel    <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite  <= wr;
		o_paddr   <= a;
		o_pwdata  <= wd;
		@(posedge i_sys_clk);
		o_penable <= 1'b1;
		do @(posedge i_sys_clk); while (i_pready !== 1'b1);
		rd = i_prdata;
		err = i_pslverr;
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
	endtask

	// callers keep test_only_bits zero in d
	task automatic send_cmd(input logic [6:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic        err;
		xfer(1'b1, '0, {16'h0, 1'b0, idx, d}, rd, err);
	endtask
endmodule

// file: adm_mode_bank_bench.sv
// Purpose: self-checking bench of the mode control bank
// Assumes: zero-wait apb slave, single 200 MHz clock
// Notes:   outputs are sampled on the falling edge, read data and slave error at the rising edge
`timescale 1ns/100ps
module adm_mode_bank_bench;
	logic               i_sys_clk;
	logic               i_arst_n;
	logic               psel, penable, pwrite, pready, pslverr;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rdv;
	logic               base_low, lzero, rzero, irq, rerr;
	logic               i2s, ljf, fval, dval;
	logic [7:0]         osr;
	logic [4:0]         rjb;
	logic [3:0]         b;
	adm_pkg::adm_mode_s mode, exp_m;
	adm_pkg::adm_zpin_s zpins;
	int                 error_cnt, n_checks;
	int                 rj_tab [8] = '{24, 20, 18, 16, 0, 0, 0, 0};

	adm_host_model adm_host_model_i (.i_sys_clk(i_sys_clk),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
		.o_paddr(paddr), .o_pwdata(pwdata), .i_pready(pready),
		.i_pslverr(pslverr), .i_prdata(prdata));

	adm_mode_bank adm_mode_bank_i (.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
		.i_base_clk_low(base_low), .i_left_zero(lzero),
		.i_right_zero(rzero), .o_mode(mode), .o_osr_ratio(osr),
		.o_rj_word_bits(rjb), .o_i2s_frame(i2s),
		.o_left_just_frame(ljf), .o_fmt_valid(fval),
		.o_deemph_rate_valid(dval), .o_zero_pins(zpins), .o_irq(irq));

	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic cmd(input logic [6:0] idx, input logic [7:0] d);
		adm_host_model_i.send_cmd(idx, d);
		@(negedge i_sys_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		adm_host_model_i.xfer(1'b1, {4'h0, a}, d, rdv, rerr);
		@(negedge i_sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic e);
		adm_host_model_i.xfer(1'b0, {4'h0, a}, 32'h0, rdv, rerr);
		chk(rdv, exp, "read data");
		chk({31'h0, rerr}, {31'h0, e}, "slave error");
	endtask

	task automatic chk_mode();
		chk({19'h0, mode}, {19'h0, exp_m}, "mode fields");
	endtask

	// long enough for every scenario with wide margin
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		error_cnt = 0;
		n_checks = 0;
		i_arst_n = 1'b0;
		base_low = 1'b0;
		lzero = 1'b0;
		rzero = 1'b0;
		repeat (10) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		@(negedge i_sys_clk);
		exp_m = adm_pkg::ADM_MODE_DEFAULT;
		chk_mode();
		chk({24'h0, osr}, 32'h40, "ratio");
		chk({29'h0, ljf, fval, dval}, 32'h7, "flags");
		for (int c = 0; c < 8; c++) begin
			cmd(adm_pkg::ADM_IDX_FORMAT_FILTER, 8'(c));
			exp_m.audio_word_format = 3'(c);
			chk_mode();
			chk({27'h0, rjb}, 32'(rj_tab[c]), "rj bits");
			chk({29'h0, i2s, ljf, fval},
				{29'h0, c == 4, c == 5, c < 6}, "frame");
		end
		cmd(adm_pkg::ADM_IDX_FORMAT_FILTER, 8'h23);
		exp_m.rolloff_select = 1'b1;
		exp_m.audio_word_format = 3'h3;
		chk_mode();
		for (int r = 0; r < 4; r++) begin
			cmd(adm_pkg::ADM_IDX_OUTPUT_DEEMPH,
				8'((r << 5) | ((r & 1) << 4) | (3 - r)));
			exp_m.deemph_rate_sel = 2'(r);
			exp_m.deemph_on = 1'(r & 1);
			exp_m.channel_output_off = 2'(3 - r);
			chk_mode();
			chk({31'h0, dval}, {31'h0, r != 3}, "rate valid");
		end
		for (int k = 0; k < 16; k++) begin
			b = 4'(k);
			cmd(adm_pkg::ADM_IDX_PHASE_ZERO, {5'h0, b[3:2], b[0]});
			exp_m.zero_flag_merge = b[3];
			exp_m.zero_flag_polarity = b[2];
			exp_m.phase_invert = b[0];
			chk_mode();
			@(posedge i_sys_clk);
			lzero <= b[1];
			rzero <= b[0];
			repeat (2) @(posedge i_sys_clk);
			@(negedge i_sys_clk);
			chk({30'h0, zpins}, {30'h0,
				(b[3] ? b[1] & b[0] : b[0]) ^ b[2],
				b[3] ? b[2] : b[1] ^ b[2]}, "zero pins");
		end
		for (int k = 0; k < 4; k++) begin
			b = 4'(k);
			cmd(adm_pkg::ADM_IDX_RATE_RESET, {1'b0, b[0], 6'h0});
			exp_m.over_sel = b[0];
			@(posedge i_sys_clk);
			base_low <= b[1];
			repeat (2) @(posedge i_sys_clk);
			@(negedge i_sys_clk);
			chk({24'h0, osr}, b[1] ? (b[0] ? 32'h40 : 32'h20)
				: (b[0] ? 32'h80 : 32'h40), "ratio");
			chk_mode();
		end
		// refused words leave every field alone
		cmd(7'h15, 8'h01);
		wr(adm_pkg::ADM_OFF_CMD_WORD, 32'h9401);
		chk_mode();
		rd(8'h50, 32'h23, 1'b0);
		wr(8'h50, 32'h0);
		rd(8'h50, 32'h23, 1'b0);
		rd(8'h0C, 32'h0, 1'b1);
		rd(adm_pkg::ADM_OFF_CMD_WORD, 32'h0, 1'b0);
		wr(adm_pkg::ADM_OFF_INT_STAT, 32'h7);
		rd(adm_pkg::ADM_OFF_INT_STAT, 32'h0, 1'b0);
		wr(adm_pkg::ADM_OFF_INT_MASK, 32'h2);
		cmd(adm_pkg::ADM_IDX_PHASE_ZERO, 8'h00);
		@(negedge i_sys_clk);
		chk({31'h0, irq}, 32'h0, "masked irq");
		cmd(7'h11, 8'h00);
		@(negedge i_sys_clk);
		chk({31'h0, irq}, 32'h1, "irq raised");
		rd(adm_pkg::ADM_OFF_INT_STAT, 32'h3, 1'b0);
		wr(adm_pkg::ADM_OFF_INT_STAT, 32'h2);
		@(negedge i_sys_clk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		rd(adm_pkg::ADM_OFF_INT_MASK, 32'h2, 1'b0);
		wr(adm_pkg::ADM_OFF_INT_STAT, 32'h7);
		cmd(adm_pkg::ADM_IDX_RATE_RESET, 8'hC0);
		exp_m = adm_pkg::ADM_MODE_DEFAULT;
		chk_mode();
		// accept and reinit events, nothing else since the last clear
		adm_host_model_i.xfer(1'b0, {4'h0, adm_pkg::ADM_OFF_INT_STAT},
			32'h0, rdv, rerr);
		chk(rdv, 32'h5, "reinit event");
		finish_test();
	end
endmodule
